// *** saa_pkg.sv ***
/*
 * Constants and carrier types of the supply alarm aggregator.
 * Assumes an 8-bit register port driven by the serial bus access logic on the same clock.
 */
package saa_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] SAA_ADDR_QT     = 8'h8e;
	localparam logic [7:0] SAA_ADDR_OCTRL  = 8'h8f;
	localparam logic [7:0] SAA_ADDR_HMV    = 8'h90;
	localparam logic [7:0] SAA_ADDR_HMC    = 8'h91;
	localparam logic [7:0] SAA_ADDR_FMV    = 8'h92;
	localparam logic [7:0] SAA_ADDR_FMC    = 8'h93;
	localparam logic [7:0] SAA_ADDR_LMV    = 8'h94;
	localparam logic [7:0] SAA_ADDR_LMC    = 8'h95;
	localparam logic [7:0] SAA_ADDR_GPO    = 8'h98;
	localparam logic [7:0] SAA_ADDR_CMD    = 8'h99;
	localparam logic [7:0] SAA_ADDR_STV    = 8'h9a;
	localparam logic [7:0] SAA_ADDR_STC    = 8'h9b;
	localparam logic [7:0] SAA_ADDR_NVV    = 8'h9e;
	localparam logic [7:0] SAA_ADDR_NVC    = 8'h9f;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the output control and command registers
	localparam int SAA_OC_HPOL  = 0;
	localparam int SAA_OC_HLAT  = 1;
	localparam int SAA_OC_HRST  = 2;
	localparam int SAA_OC_FPOL  = 3;
	localparam int SAA_OC_FLAT  = 4;
	localparam int SAA_OC_FRST  = 5;
	localparam int SAA_OC_OVIGN = 6;
	localparam int SAA_OC_CHSEL = 7;
	localparam int SAA_CMD_CLR  = 0;
	localparam int SAA_CMD_RST  = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Quick-trip thresholds in mV, low and high member of each pair
	localparam logic [7:0] SAA_QT_OFF  = 8'h00;
	localparam logic [7:0] SAA_QT1_LO  = 8'h32;
	localparam logic [7:0] SAA_QT1_HI  = 8'h4b;
	localparam logic [7:0] SAA_QT2_LO  = 8'h4b;
	localparam logic [7:0] SAA_QT2_HI  = 8'h64;
	localparam logic [7:0] SAA_QT3_LO  = 8'h7d;
	localparam logic [7:0] SAA_QT3_HI  = 8'h96;
	localparam logic [7:0] SAA_REG_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [3:0] overvoltage_flag;
		logic [3:0] undervoltage_flag;
		logic [3:0] overcurrent_flag;
		logic [3:0] window_alarm_flag;
	} saa_cond_s;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} saa_reg_req_s;

	typedef struct packed {
		logic [7:0]  qt_sel;
		logic [7:0]  out_ctrl;
		logic [15:0] hmask;
		logic [15:0] fmask;
		logic [15:0] lmask;
		logic [3:0]  gpo;
		logic [15:0] stat;
		logic [15:0] nv;
		logic        nv_irq_n;
		logic        health;
		logic        fault;
		logic        health_pin;
		logic        fault_pin;
		logic        soft_rst;
		logic [7:0]  rdata;
		logic [15:0] cond_s1;
		logic [15:0] cond_s2;
		logic        ovr_s1;
		logic        ovr_s2;
		logic        clr_s1;
		logic        clr_s2;
		logic [31:0] qt_mv;
	} saa_state_s;

	// Maps a 2-bit quick-trip code to a threshold; vref_hi picks the pair member
	function automatic logic [7:0] saa_qt_lookup(input logic [1:0] code, input logic vref_hi);
		logic [7:0] mv;
		case (code)
			2'h1: mv = vref_hi ? SAA_QT1_HI : SAA_QT1_LO;
			2'h2: mv = vref_hi ? SAA_QT2_HI : SAA_QT2_LO;
			2'h3: mv = vref_hi ? SAA_QT3_HI : SAA_QT3_LO;
			default: mv = SAA_QT_OFF;
		endcase
		return mv;
	endfunction

endpackage

// *** saa_aggregator.sv ***
/*
 * Alarm aggregation logic: masks, health/failure indicators, status, NV fault latches,
 * general outputs, soft command. Assumes the serial bus access control presents a
 * same-clock register port, and that comparator flags and alarm pins are asynchronous.
 */
// Summary of operation
// - Quick-trip register holds 2-bit code per channel 4..7; 00 off, higher codes higher pairs.
// - Configuration reference bit picks which member of each quick-trip pair applies.
// - Output control bit 0 sets health indicator polarity, 1 active high.
// - Output control bit 1 latches the health indicator when set.
// - Output control bit 2 forces health false during device reset.
// - Output control bit 3 sets failure indicator polarity, 1 active high.
// - Output control bit 4 latches the failure indicator once asserted.
// - Output control bit 5 forces failure true during device reset.
// - Bit 6 low lets the undervoltage override suppress failure; high ignores it.
// - Bit 7 selects enabled or disabled channels as indicator sources.
// - Interrupt-clear input clears every latched health or failure condition.
// - Health is true only while all selected sources are within limits.
// - Failure is true when any selected source is out of limits.
// - First health mask: over-voltage 7..4 in bits 7..4, under-voltage in 3..0.
// - Second health mask: over-current 7..4 high nibble, limit alarms 3..0 low.
// - Failure masks share the health layout; a one activates failure.
// - Latch-masked conditions set NV fault latch bits and pull the NV interrupt low.
// - General output register sets the four open-collector output levels.
// - Command bit 0 clears all interrupts except the NV fault interrupt.
// - Command bit 1 starts a reset-output cycle and then clears itself.
// - Status registers are volatile read-only records of interrupt-causing conditions.
// - Driving the interrupt-clear input low clears both status registers.
// - NV latch bits persist and clear only when software writes zero there.
`timescale 1ns/100ps
module saa_aggregator (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire saa_pkg::saa_cond_s   cond_i,
	input  wire logic [15:0]          chan_en_i,
	input  wire logic                 vref_sel_i,
	input  wire logic                 nv_latch_enable_i,
	input  wire logic                 undervolt_ignore_input_n_i,
	input  wire logic                 irq_clear_n_i,
	input  wire logic                 dev_reset_i,
	input  wire logic [15:0]          nv_image_i,
	input  wire saa_pkg::saa_reg_req_s reg_req_i,
	output logic [7:0]                reg_rdata_o,
	output logic                      healthy_o,
	output logic                      fault_o,
	output logic                      nv_failure_irq_n_o,
	output logic [15:0]               nv_image_o,
	output logic [3:0]                general_output_bit_o,
	output logic                      soft_reset_req_o,
	output logic [31:0]               quick_trip_mv_o
);
	import saa_pkg::*;

	saa_state_s  s;
	saa_state_s  next_s;
	logic        clr;
	logic        ovr_act;
	logic        wr_octrl;
	logic        h_raw;
	logic        f_raw;
	logic [15:0] src;
	logic [15:0] nv_hit;

	function automatic logic wr_hit(input saa_reg_req_s req, input logic [7:0] addr);
		return req.wr && (req.addr == addr);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Source selection and raw indicator terms
	always_comb begin
		// Soft clear acts in the same cycle as the write, pin clear after synchronising
		clr = ~s.clr_s2 | (wr_hit(reg_req_i, SAA_ADDR_CMD) & reg_req_i.wdata[SAA_CMD_CLR]);
		ovr_act = ~s.ovr_s2 & ~s.out_ctrl[SAA_OC_OVIGN];
		wr_octrl = wr_hit(reg_req_i, SAA_ADDR_OCTRL);
		src = s.cond_s2 & (s.out_ctrl[SAA_OC_CHSEL] ? ~chan_en_i : chan_en_i);
		h_raw = ~|(src & s.hmask);
		f_raw = (|(src & s.fmask)) & ~ovr_act;
		nv_hit = s.cond_s2 & s.lmask & {16{nv_latch_enable_i}};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic h_eff;
		logic f_eff;
		logic [15:0] keep;
		h_eff = 1'b0;
		f_eff = 1'b0;
		keep = s.nv;
		next_s = s;
		next_s.cond_s1 = cond_i;
		next_s.cond_s2 = s.cond_s1;
		next_s.ovr_s1 = undervolt_ignore_input_n_i;
		next_s.ovr_s2 = s.ovr_s1;
		next_s.clr_s1 = irq_clear_n_i;
		next_s.clr_s2 = s.clr_s1;

		case (1'b1)
			wr_hit(reg_req_i, SAA_ADDR_QT):    next_s.qt_sel = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_OCTRL): next_s.out_ctrl = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_HMV):   next_s.hmask[15:8] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_HMC):   next_s.hmask[7:0] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_FMV):   next_s.fmask[15:8] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_FMC):   next_s.fmask[7:0] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_LMV):   next_s.lmask[15:8] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_LMC):   next_s.lmask[7:0] = reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_GPO):   next_s.gpo = reg_req_i.wdata[3:0];
			wr_hit(reg_req_i, SAA_ADDR_NVV):   keep[15:8] = s.nv[15:8] & reg_req_i.wdata;
			wr_hit(reg_req_i, SAA_ADDR_NVC):   keep[7:0] = s.nv[7:0] & reg_req_i.wdata;
			default: ;
		endcase

		// Writing one cannot set a latch; a new hit in the clearing cycle still wins
		next_s.nv = keep | nv_hit;
		next_s.nv_irq_n = ~|next_s.nv;
		next_s.stat = (clr ? 16'h0000 : s.stat) | src;

		// Clear re-evaluates rather than zeroes, so a condition still present survives it
		if (clr || !s.out_ctrl[SAA_OC_HLAT]) begin
			next_s.health = h_raw;
		end else begin
			next_s.health = s.health & h_raw;
		end
		if (clr || !s.out_ctrl[SAA_OC_FLAT]) begin
			next_s.fault = f_raw;
		end else begin
			next_s.fault = s.fault | f_raw;
		end
		h_eff = next_s.health & ~(dev_reset_i & s.out_ctrl[SAA_OC_HRST]);
		f_eff = next_s.fault | (dev_reset_i & s.out_ctrl[SAA_OC_FRST]);
		next_s.health_pin = s.out_ctrl[SAA_OC_HPOL] ? h_eff : ~h_eff;
		next_s.fault_pin = s.out_ctrl[SAA_OC_FPOL] ? f_eff : ~f_eff;

		// One-cycle request; the command bit never reads back as one
		next_s.soft_rst = wr_hit(reg_req_i, SAA_ADDR_CMD) & reg_req_i.wdata[SAA_CMD_RST];

		// Channel 4 owns the top code bits but the bottom output byte
		for (int ch = 0; ch < 4; ch++) begin
			next_s.qt_mv[ch*8 +: 8] = saa_qt_lookup(s.qt_sel[(3 - ch)*2 +: 2], vref_sel_i);
		end

		case (reg_req_i.addr)
			SAA_ADDR_QT:    next_s.rdata = s.qt_sel;
			SAA_ADDR_OCTRL: next_s.rdata = s.out_ctrl;
			SAA_ADDR_HMV:   next_s.rdata = s.hmask[15:8];
			SAA_ADDR_HMC:   next_s.rdata = s.hmask[7:0];
			SAA_ADDR_FMV:   next_s.rdata = s.fmask[15:8];
			SAA_ADDR_FMC:   next_s.rdata = s.fmask[7:0];
			SAA_ADDR_LMV:   next_s.rdata = s.lmask[15:8];
			SAA_ADDR_LMC:   next_s.rdata = s.lmask[7:0];
			SAA_ADDR_GPO:   next_s.rdata = {4'h0, s.gpo};
			SAA_ADDR_STV:   next_s.rdata = s.stat[15:8];
			SAA_ADDR_STC:   next_s.rdata = s.stat[7:0];
			SAA_ADDR_NVV:   next_s.rdata = s.nv[15:8];
			SAA_ADDR_NVC:   next_s.rdata = s.nv[7:0];
			default:        next_s.rdata = SAA_REG_RST;
		endcase

		// Latches reload from the nonvolatile image; everything else starts clean
		if (sys_rst_i) begin
			next_s = '0;
			next_s.health = 1'b1;
			next_s.fault_pin = 1'b1;
			next_s.ovr_s1 = 1'b1;
			next_s.ovr_s2 = 1'b1;
			next_s.clr_s1 = 1'b1;
			next_s.clr_s2 = 1'b1;
			next_s.nv = nv_image_i;
			next_s.nv_irq_n = ~|nv_image_i;
		end
	end

	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	assign reg_rdata_o = s.rdata;
	assign healthy_o = s.health_pin;
	assign fault_o = s.fault_pin;
	assign nv_failure_irq_n_o = s.nv_irq_n;
	assign nv_image_o = s.nv;
	assign general_output_bit_o = s.gpo;
	assign soft_reset_req_o = s.soft_rst;
	assign quick_trip_mv_o = s.qt_mv;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	AST_NV_IRQ_LOW: assert property ((|s.nv) |-> !nv_failure_irq_n_o)
		else $error("NV interrupt high while a latch bit is set");
	AST_NV_RECORD: assert property ((nv_hit != 16'h0000) |=> (s.nv & $past(nv_hit)) == $past(nv_hit))
		else $error("Latch-masked condition not recorded");
	AST_NV_WRITE_CLEAR: assert property ((wr_hit(reg_req_i, SAA_ADDR_NVV) && nv_hit[15:8] == 8'h00)
		|=> (s.nv[15:8] & ~$past(reg_req_i.wdata)) == 8'h00)
		else $error("NV latch bit not cleared by zero write");
	AST_STAT_CLEAR: assert property ((!s.clr_s2 && src == 16'h0000) |=> s.stat == 16'h0000)
		else $error("Status not cleared by clear pin");
	AST_SOFT_RST: assert property ((wr_hit(reg_req_i, SAA_ADDR_CMD) && reg_req_i.wdata[SAA_CMD_RST])
		|=> soft_reset_req_o ##1 !soft_reset_req_o)
		else $error("Soft reset request not a single pulse");
	AST_HEALTH_AND: assert property (!h_raw |=> !s.health)
		else $error("Health true with a selected source out of limits");
	AST_FAULT_OR: assert property (f_raw |=> s.fault)
		else $error("Failure missing with a selected source out of limits");
	AST_HEALTH_POL: assert property ((!$past(dev_reset_i) && !$past(sys_rst_i))
		|-> healthy_o == ($past(s.out_ctrl[SAA_OC_HPOL]) ~^ s.health))
		else $error("Health pin polarity wrong");
	AST_FAULT_LATCH: assert property ((s.out_ctrl[SAA_OC_FLAT] && s.fault && !clr && !wr_octrl) |=> s.fault)
		else $error("Latched failure dropped without clear");
	AST_FAULT_RST_FORCE: assert property ((dev_reset_i && s.out_ctrl[SAA_OC_FRST] && !wr_octrl)
		|=> fault_o == $past(s.out_ctrl[SAA_OC_FPOL]))
		else $error("Failure pin not forced true in device reset");
	AST_HEALTH_RST_FORCE: assert property ((dev_reset_i && s.out_ctrl[SAA_OC_HRST] && !wr_octrl)
		|=> healthy_o == !$past(s.out_ctrl[SAA_OC_HPOL]))
		else $error("Health pin not forced false in device reset");
	AST_UV_OVERRIDE: assert property ((ovr_act && !s.out_ctrl[SAA_OC_FLAT] && !wr_octrl) |=> !s.fault)
		else $error("Override did not suppress failure");

	COV_HEALTH_FALL: cover property (s.health ##1 !s.health);
	COV_NV_IRQ: cover property (nv_failure_irq_n_o ##1 !nv_failure_irq_n_o);
	COV_SOFT_RST: cover property (soft_reset_req_o);
	COV_FAULT_LATCHED: cover property (s.out_ctrl[SAA_OC_FLAT] && s.fault && !f_raw);

endmodule

// *** saa_host_model.sv ***
/*
 * Host model: drives the aggregator's register port.
 * Assumes a same-clock port, taken on the rising edge.
 */
`timescale 1ns/100ps
module saa_host_model (
	input  wire logic             clk_i,
	output saa_pkg::saa_reg_req_s reg_req_o
);
	import saa_pkg::*;
	initial reg_req_o = '0;
	////////////////////////////////////////////////////////////////////////////////
	// A write is held up to its taking edge, then the strobe drops
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_req_o <= '{wr: 1'b1, addr: a, wdata: d};
		@(posedge clk_i);
		reg_req_o.wr <= 1'b0;
	endtask
	// Returns once read data for the address is settled
	task automatic read_reg(input logic [7:0] a);
		@(posedge clk_i);
		reg_req_o <= '{wr: 1'b0, addr: a, wdata: ~a};
		@(posedge clk_i);
		#1;
	endtask
	task automatic clear_irq();
		write_reg(SAA_ADDR_CMD, 8'h01);
	endtask
	task automatic soft_reset();
		write_reg(SAA_ADDR_CMD, 8'h02);
	endtask
	// Ones are written where a latch bit must stay
	task automatic nv_write(input logic [7:0] a, input logic [7:0] keep);
		write_reg(a, keep);
	endtask
endmodule

// *** test_supply_alarm_aggregator.sv ***
/*
 * Self-checking bench of the alarm aggregator.
 * Assumes the host model drives the register port; checks go through a note queue, except the soft-reset pulse count.
 */
`timescale 1ns/100ps
module test_supply_alarm_aggregator;
	import saa_pkg::*;
	typedef struct packed {
		logic [3:0]  sel;
		logic [31:0] val;
	} saa_note_s;
	logic         clk     = 1'b0;
	logic         rst     = 1'b1;
	saa_cond_s    cond    = '0;
	logic [15:0]  chan_en = 16'hffff;
	logic         vref    = 1'b0;
	logic         nv_en   = 1'b0;
	logic         uvi_n   = 1'b1;
	logic         clr_n   = 1'b1;
	logic         dev_rst = 1'b0;
	logic [15:0]  nv_img  = 16'h0000;
	saa_reg_req_s req;
	logic [7:0]   rdata;
	logic         healthy, fault, nv_irq_n, soft_rst;
	logic [15:0]  nv_out;
	logic [3:0]   gpo;
	logic [31:0]  qt_mv, r, cnt;
	logic [31:0]  rng = 32'd18;
	int           n_fail = 0;
	int           tests_run = 0;
	saa_note_s    notes[$];
	saa_note_s    n;
	always #2 clk = ~clk;
	saa_host_model u_host (.clk_i(clk), .reg_req_o(req));
	saa_aggregator dut (.clk_i(clk), .sys_rst_i(rst), .cond_i(cond), .chan_en_i(chan_en), .vref_sel_i(vref),
		.nv_latch_enable_i(nv_en), .undervolt_ignore_input_n_i(uvi_n), .irq_clear_n_i(clr_n),
		.dev_reset_i(dev_rst), .nv_image_i(nv_img), .reg_req_i(req), .reg_rdata_o(rdata), .healthy_o(healthy),
		.fault_o(fault), .nv_failure_irq_n_o(nv_irq_n), .nv_image_o(nv_out), .general_output_bit_o(gpo),
		.soft_reset_req_o(soft_rst), .quick_trip_mv_o(qt_mv));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [31:0] qt_exp(input logic [7:0] q, input logic hi);
		logic [7:0] lo_t [4] = '{8'd0, 8'd50, 8'd75, 8'd125};
		logic [7:0] hi_t [4] = '{8'd0, 8'd75, 8'd100, 8'd150};
		for (int k = 0; k < 4; k++) qt_exp[8*k +: 8] = hi ? hi_t[q[7-2*k -: 2]] : lo_t[q[7-2*k -: 2]];
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] e, input logic [3:0] sel);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t output %0d seen %h expected %h", $time, sel, s, e);
		end
	endtask
	task automatic note(input logic [3:0] sel, input logic [31:0] val);
		notes.push_back('{sel, val});
	endtask
	// Watcher takes notes once outputs have settled after the edge
	always @(posedge clk) begin
		#1;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
				4'h0: check({24'h0, rdata}, n.val, n.sel);
				4'h1: check({31'h0, healthy}, n.val, n.sel);
				4'h2: check({31'h0, fault}, n.val, n.sel);
				4'h3: check({31'h0, nv_irq_n}, n.val, n.sel);
				4'h4: check({16'h0, nv_out}, n.val, n.sel);
				4'h5: check({28'h0, gpo}, n.val, n.sel);
				default: check(qt_mv, n.val, n.sel);
			endcase
		end
	end
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic set_cond(input logic [15:0] c);
		@(posedge clk);
		cond <= c;
		tick(4);
	endtask
	task automatic octrl(input logic [7:0] v);
		u_host.write_reg(SAA_ADDR_OCTRL, v);
		tick(2);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Whole run is about 180 cycles
	initial begin
		tick(3000);
		n_fail++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(4);
		rst <= 1'b0;
		for (int a = 8'h8e; a <= 8'h9f; a++) begin
			u_host.read_reg(a[7:0]);
			note(0, 0);
		end
		note(1, 0);
		note(2, 1);
		$display("reset values done");
		for (int i = 0; i < 6; i++) begin
			r = (i < 2) ? {23'h0, i[0], 8'h1b} : xorshift();
			u_host.write_reg(SAA_ADDR_QT, r[7:0]);
			vref <= r[8];
			tick(3);
			note(6, qt_exp(r[7:0], r[8]));
		end
		r = xorshift();
		u_host.write_reg(SAA_ADDR_GPO, r[7:0]);
		u_host.read_reg(SAA_ADDR_GPO);
		note(5, r[3:0]);
		note(0, r[3:0]);
		$display("quick trip and outputs done");
		u_host.write_reg(SAA_ADDR_FMV, 8'h80);
		u_host.write_reg(SAA_ADDR_HMC, 8'h01);
		set_cond(16'h8000);
		note(2, 0);
		note(1, 0);
		u_host.read_reg(SAA_ADDR_STV);
		note(0, 8'h80);
		octrl(8'h09);
		note(2, 1);
		note(1, 1);
		set_cond(16'h8001);
		note(1, 0);
		octrl(8'h00);
		uvi_n <= 1'b0;
		tick(5);
		note(2, 1);
		octrl(8'h40);
		note(2, 0);
		uvi_n <= 1'b1;
		octrl(8'h80);
		note(2, 1);
		$display("aggregation done");
		octrl(8'h12);
		set_cond(16'h0000);
		note(2, 0);
		note(1, 1);
		clr_n <= 1'b0;
		tick(5);
		clr_n <= 1'b1;
		tick(3);
		note(2, 1);
		note(1, 0);
		u_host.read_reg(SAA_ADDR_STV);
		note(0, 0);
		set_cond(16'h0001);
		set_cond(16'h0000);
		u_host.read_reg(SAA_ADDR_STC);
		note(0, 1);
		u_host.clear_irq();
		u_host.read_reg(SAA_ADDR_STC);
		note(0, 0);
		octrl(8'h24);
		dev_rst <= 1'b1;
		tick(3);
		note(1, 1);
		note(2, 0);
		dev_rst <= 1'b0;
		$display("latching and clearing done");
		nv_en <= 1'b1;
		u_host.write_reg(SAA_ADDR_LMV, 8'h01);
		set_cond(16'h0100);
		set_cond(16'h0000);
		note(4, 16'h0100);
		note(3, 0);
		u_host.nv_write(SAA_ADDR_NVV, 8'h01);
		tick(2);
		note(4, 16'h0100);
		u_host.nv_write(SAA_ADDR_NVV, 8'h00);
		tick(2);
		note(4, 0);
		note(3, 1);
		u_host.soft_reset();
		cnt = 0;
		repeat (3) begin
			#1;
			cnt += soft_rst;
			@(posedge clk);
		end
		check(cnt, 1, 4'h7);
		u_host.read_reg(SAA_ADDR_CMD);
		note(0, 0);
		$display("fault latch and command done");
		tick(2);
		give_verdict();
	end
endmodule
